// ---- ldi_pkg.sv ----
package ldi_pkg;
    // bus address, seven bits, and the direction bit of a write
    localparam logic [6:0] LDI_DEV_ADDR = 7'h39;
    localparam logic LDI_DIR_WRITE = 1'b0;
    // block selector codes carried in the second byte
    localparam logic [7:0] LDI_SEL_BACKLIGHT = 8'h01;
    localparam logic [7:0] LDI_SEL_FLASH = 8'h02;
    // bytes in one programming frame
    localparam logic [1:0] LDI_FRAME_BYTES = 2'h3;
    // field positions inside the level registers
    localparam int LDI_BK_CODE_MSB = 4;
    localparam int LDI_BK_FOURTH_BIT = 7;
    localparam int LDI_FL_CODE_MSB = 6;
    // level register reset value
    localparam logic [7:0] LDI_LEVEL_RESET = 8'h00;
    // current scaling and limits, in mA
    localparam logic [10:0] LDI_MULT_STEP = 11'h028;
    localparam logic [7:0] LDI_BK_CAP_MA = 8'h1e;
    localparam logic [7:0] LDI_FL_CAP_MA = 8'h64;
    localparam logic [9:0] LDI_TOTAL_CAP_MA = 10'h1f4;
    // clock and timing
    localparam int LDI_CLK_KHZ = 25000;
    localparam int LDI_PUMP_KHZ = 1300;
    localparam int LDI_PUMP_HALF_CYC = LDI_CLK_KHZ / (2 * LDI_PUMP_KHZ);
    localparam int LDI_SCL_MAX_KHZ = 400;
    localparam int LDI_SCL_QUARTER_CYC = (LDI_CLK_KHZ + 4 * LDI_SCL_MAX_KHZ - 1)
        / (4 * LDI_SCL_MAX_KHZ);
    // controller register offsets and reset values
    localparam logic [1:0] LDI_REG_TARGET = 2'h0;
    localparam logic [1:0] LDI_REG_VALUE = 2'h1;
    localparam logic [1:0] LDI_REG_STATUS = 2'h2;
    localparam logic [1:0] LDI_REG_ADDRESS = 2'h3;
    localparam logic [7:0] LDI_TARGET_RESET = 8'h01;
    localparam int LDI_STATUS_BUSY_BIT = 0;
    localparam int LDI_STATUS_NACK_BIT = 1;
endpackage

// ---- ldi_bus_if.sv ----
`timescale 1ns/1ps
interface ldi_bus_if;
    logic scl_host_o;
    logic scl_host_oe;
    logic sda_host_o;
    logic sda_host_oe;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic scl;
    logic sda;
    // open-drain wires with pull-ups: any enabled low driver wins
    assign scl = !(scl_host_oe && !scl_host_o);
    assign sda = !((sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o));
    modport host (output scl_host_o, scl_host_oe, sda_host_o, sda_host_oe, input scl, sda);
    modport device (output sda_dev_o, sda_dev_oe, input scl, sda);
endinterface

// ---- ldi_sync.sv ----
`timescale 1ns/1ps
module ldi_sync #(
    parameter int WIDTH = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // asynchronous inputs and their synchronised copies
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    // first stage feeds only the second; idle lines rest high
    genvar i;
    for (i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clk) begin
            if (reset) begin
                stage1[i] <= 1'b1;
                sync_out[i] <= 1'b1;
            end else begin
                stage1[i] <= async_in[i];
                sync_out[i] <= stage1[i];
            end
        end
    end
endmodule

// ---- ldi_device.sv ----
`timescale 1ns/1ps
module ldi_device import ldi_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // serial bus
    ldi_bus_if.device bus,
    // analog monitor
    input wire logic overvoltage_guard,
    // level registers
    output logic [7:0] backlight_level,
    output logic [7:0] flash_level,
    // derived controls
    output logic fourth_backlight_enable,
    output logic [10:0] backlight_multiplier,
    output logic [7:0] backlight_current_ma,
    output logic [7:0] flash_current_ma,
    output logic converter_enable,
    output logic pump_charge,
    output logic pump_transfer
);
    typedef enum logic [3:0] {
        LDI_IDLE = 4'h1,
        LDI_RECV = 4'h2,
        LDI_ACK = 4'h4,
        LDI_SKIP = 4'h8
    } ldi_dev_state_t;

    function automatic logic [7:0] ldi_cap(input logic [7:0] v, input logic [7:0] lim);
        ldi_cap = (v > lim) ? lim : v;
    endfunction

    ldi_dev_state_t state;
    logic [2:0] sync_q;
    logic scl_s;
    logic sda_s;
    logic ovp_s;
    logic scl_d;
    logic sda_d;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic [7:0] shreg;
    logic [7:0] byte_in;
    logic [3:0] bit_cnt;
    logic [1:0] byte_idx;
    logic [7:0] selector;
    logic addressed;
    logic ack_pend;
    logic [7:0] next_bk_ma;
    logic [9:0] bk_total;
    logic [9:0] fl_room;
    logic [7:0] next_fl_ma;
    logic [7:0] pump_cnt;
    logic pump_run;

    ldi_sync #(.WIDTH(3)) u_sync (
        .clk(clk),
        .reset(reset),
        .async_in({overvoltage_guard, bus.sda, bus.scl}),
        .sync_out(sync_q)
    );
    assign scl_s = sync_q[0];
    assign sda_s = sync_q[1];
    assign ovp_s = sync_q[2];

    always_ff @(posedge clk) begin
        if (reset) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    assign scl_rise = scl_s && !scl_d;
    assign scl_fall = !scl_s && scl_d;
    assign start_seen = scl_s && scl_d && sda_d && !sda_s;
    assign stop_seen = scl_s && scl_d && !sda_d && sda_s;
    assign byte_in = {shreg[6:0], sda_s};

    // slave only: sda is only ever pulled low for acknowledge
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= LDI_IDLE;
            shreg <= 8'h00;
            bit_cnt <= 4'h0;
            byte_idx <= 2'h0;
            selector <= 8'h00;
            addressed <= 1'b0;
            ack_pend <= 1'b0;
            bus.sda_dev_o <= 1'b0;
            bus.sda_dev_oe <= 1'b0;
        end else if (start_seen) begin
            state <= LDI_RECV;
            bit_cnt <= 4'h0;
            byte_idx <= 2'h0;
            addressed <= 1'b0;
            bus.sda_dev_oe <= 1'b0;
        end else if (stop_seen) begin
            state <= LDI_IDLE;
            bus.sda_dev_oe <= 1'b0;
        end else begin
            case (state)
                LDI_IDLE: begin
                    bus.sda_dev_oe <= 1'b0;
                end
                LDI_RECV: begin
                    if (scl_rise && bit_cnt < 4'h8) begin
                        shreg <= byte_in;
                        bit_cnt <= bit_cnt + 4'h1;
                        if (bit_cnt == 4'h7) begin
                            case (byte_idx)
                                2'h0: begin
                                    addressed <= (byte_in[7:1] == LDI_DEV_ADDR)
                                        && (byte_in[0] == LDI_DIR_WRITE);
                                    ack_pend <= (byte_in[7:1] == LDI_DEV_ADDR)
                                        && (byte_in[0] == LDI_DIR_WRITE);
                                end
                                2'h1: begin
                                    selector <= byte_in;
                                    ack_pend <= addressed;
                                end
                                2'h2: ack_pend <= addressed;
                                default: ack_pend <= 1'b0;
                            endcase
                        end
                    end else if (scl_fall && bit_cnt == 4'h8) begin
                        bus.sda_dev_oe <= ack_pend;
                        state <= LDI_ACK;
                    end
                end
                LDI_ACK: begin
                    // release after the ninth clock
                    if (scl_fall) begin
                        bus.sda_dev_oe <= 1'b0;
                        bit_cnt <= 4'h0;
                        if (byte_idx != LDI_FRAME_BYTES) begin
                            byte_idx <= byte_idx + 2'h1;
                        end
                        state <= addressed ? LDI_RECV : LDI_SKIP;
                    end
                end
                LDI_SKIP: begin
                    bus.sda_dev_oe <= 1'b0;
                end
                default: begin
                    state <= LDI_IDLE;
                    bus.sda_dev_oe <= 1'b0;
                end
            endcase
        end
    end

    // last rise of the third byte loads the bank
    always_ff @(posedge clk) begin
        if (reset) begin
            backlight_level <= LDI_LEVEL_RESET;
            flash_level <= LDI_LEVEL_RESET;
        end else if (state == LDI_RECV && scl_rise && bit_cnt == 4'h7
                && byte_idx == 2'h2 && addressed && !start_seen && !stop_seen) begin
            if (selector == LDI_SEL_BACKLIGHT) begin
                backlight_level <= byte_in;
            end else if (selector == LDI_SEL_FLASH) begin
                flash_level <= byte_in;
            end
        end
    end

    // binary weights, 1 mA per step
    assign next_bk_ma = ldi_cap({3'h0, backlight_level[LDI_BK_CODE_MSB:0]}, LDI_BK_CAP_MA);
    // three or four backlight LEDs share the budget
    assign bk_total = backlight_level[LDI_BK_FOURTH_BIT] ? {next_bk_ma, 2'h0}
        : ({2'h0, next_bk_ma} + {1'h0, next_bk_ma, 1'h0});
    // flash gets what the total leaves, four LEDs
    assign fl_room = (LDI_TOTAL_CAP_MA - bk_total) >> 2;
    assign next_fl_ma = ldi_cap(ldi_cap({1'h0, flash_level[LDI_FL_CODE_MSB:0]}, LDI_FL_CAP_MA),
        fl_room[7:0]);

    always_ff @(posedge clk) begin
        if (reset) begin
            fourth_backlight_enable <= 1'b0;
            backlight_multiplier <= 11'h000;
            backlight_current_ma <= 8'h00;
            flash_current_ma <= 8'h00;
            converter_enable <= 1'b0;
        end else begin
            fourth_backlight_enable <= backlight_level[LDI_BK_FOURTH_BIT];
            backlight_multiplier <= 11'(LDI_MULT_STEP * {6'h00,
                backlight_level[LDI_BK_CODE_MSB:0]});
            backlight_current_ma <= next_bk_ma;
            flash_current_ma <= next_fl_ma;
            // off only when both registers are zero
            converter_enable <= (backlight_level != 8'h00) || (flash_level != 8'h00);
        end
    end

    assign pump_run = converter_enable && !ovp_s;

    // charge and transfer alternate, never overlap
    always_ff @(posedge clk) begin
        if (reset) begin
            pump_cnt <= 8'h00;
            pump_charge <= 1'b0;
            pump_transfer <= 1'b0;
        end else if (!pump_run) begin
            pump_cnt <= 8'h00;
            pump_charge <= 1'b0;
            pump_transfer <= 1'b0;
        end else if (pump_cnt == 8'(LDI_PUMP_HALF_CYC - 1)) begin
            pump_cnt <= 8'h00;
            pump_charge <= !pump_charge;
            pump_transfer <= pump_charge;
        end else begin
            pump_cnt <= pump_cnt + 8'h01;
            if (!pump_charge && !pump_transfer) begin
                pump_charge <= 1'b1;
            end
        end
    end
endmodule

// ---- ldi_host.sv ----
`timescale 1ns/1ps
module ldi_host import ldi_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // serial bus
    ldi_bus_if.host bus,
    // register port
    input wire logic [1:0] address,
    input wire logic [7:0] write_data,
    input wire logic write_strobe,
    input wire logic read_strobe,
    output logic [7:0] read_data
);
    typedef enum logic [3:0] {
        LDI_H_IDLE = 4'h1,
        LDI_H_START = 4'h2,
        LDI_H_BITS = 4'h4,
        LDI_H_STOP = 4'h8
    } ldi_host_state_t;

    ldi_host_state_t state;
    logic [0:0] sda_sync;
    logic [7:0] target;
    logic [6:0] dev_addr;
    logic [7:0] frame [3];
    logic busy;
    logic nack;
    logic [7:0] qcnt;
    logic tick;
    logic [1:0] phase;
    logic [3:0] bit_idx;
    logic [1:0] byte_idx;
    logic [7:0] cur_byte;

    // only sda is read back; the device never stretches scl
    ldi_sync #(.WIDTH(1)) u_sync (
        .clk(clk),
        .reset(reset),
        .async_in(bus.sda),
        .sync_out(sda_sync)
    );

    assign tick = (qcnt == 8'(LDI_SCL_QUARTER_CYC - 1));
    assign cur_byte = frame[byte_idx];

    always_ff @(posedge clk) begin
        if (reset || state == LDI_H_IDLE || tick) begin
            qcnt <= 8'h00;
        end else begin
            qcnt <= qcnt + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            target <= LDI_TARGET_RESET;
            dev_addr <= LDI_DEV_ADDR;
        end else if (write_strobe && !busy) begin
            if (address == LDI_REG_TARGET) begin
                target <= write_data;
            end else if (address == LDI_REG_ADDRESS) begin
                dev_addr <= write_data[6:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            read_data <= 8'h00;
        end else if (read_strobe) begin
            case (address)
                LDI_REG_TARGET: read_data <= target;
                LDI_REG_STATUS: read_data <= {6'h00, nack, busy};
                LDI_REG_ADDRESS: read_data <= {1'h0, dev_addr};
                default: read_data <= 8'h00;
            endcase
        end else begin
            read_data <= 8'h00;
        end
    end

    // a value write launches one three-byte frame; writes while busy are dropped
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= LDI_H_IDLE;
            busy <= 1'b0;
            nack <= 1'b0;
            phase <= 2'h0;
            bit_idx <= 4'h0;
            byte_idx <= 2'h0;
            frame[0] <= 8'h00;
            frame[1] <= 8'h00;
            frame[2] <= 8'h00;
            bus.scl_host_o <= 1'b0;
            bus.scl_host_oe <= 1'b0;
            bus.sda_host_o <= 1'b0;
            bus.sda_host_oe <= 1'b0;
        end else begin
            case (state)
                LDI_H_IDLE: begin
                    bus.scl_host_oe <= 1'b0;
                    bus.sda_host_oe <= 1'b0;
                    if (write_strobe && address == LDI_REG_VALUE) begin
                        frame[0] <= {dev_addr, LDI_DIR_WRITE};
                        frame[1] <= target;
                        frame[2] <= write_data;
                        busy <= 1'b1;
                        nack <= 1'b0;
                        phase <= 2'h0;
                        bit_idx <= 4'h0;
                        byte_idx <= 2'h0;
                        state <= LDI_H_START;
                    end
                end
                LDI_H_START: begin
                    if (tick) begin
                        phase <= phase + 2'h1;
                        if (phase == 2'h1) begin
                            bus.sda_host_oe <= 1'b1;
                        end else if (phase == 2'h3) begin
                            bus.scl_host_oe <= 1'b1;
                            state <= LDI_H_BITS;
                        end
                    end
                end
                LDI_H_BITS: begin
                    if (tick) begin
                        phase <= phase + 2'h1;
                        case (phase)
                            2'h0: bus.sda_host_oe <= (bit_idx < 4'h8)
                                && !cur_byte[3'(4'h7 - bit_idx)];
                            2'h1: bus.scl_host_oe <= 1'b0;
                            2'h2: if (bit_idx == 4'h8 && sda_sync[0]) nack <= 1'b1;
                            default: begin
                                bus.scl_host_oe <= 1'b1;
                                if (bit_idx == 4'h8) begin
                                    bit_idx <= 4'h0;
                                    byte_idx <= byte_idx + 2'h1;
                                    if (nack || byte_idx == 2'h2) begin
                                        state <= LDI_H_STOP;
                                    end
                                end else begin
                                    bit_idx <= bit_idx + 4'h1;
                                end
                            end
                        endcase
                    end
                end
                LDI_H_STOP: begin
                    if (tick) begin
                        phase <= phase + 2'h1;
                        case (phase)
                            2'h0: bus.sda_host_oe <= 1'b1;
                            2'h1: bus.scl_host_oe <= 1'b0;
                            2'h2: bus.sda_host_oe <= 1'b0;
                            default: begin
                                busy <= 1'b0;
                                state <= LDI_H_IDLE;
                            end
                        endcase
                    end
                end
                default: state <= LDI_H_IDLE;
            endcase
        end
    end
endmodule

// ---- ldi_asserts.sv ----
`timescale 1ns/1ps
module ldi_asserts (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // link wires
    input wire logic scl,
    input wire logic sda_dev_oe,
    // device side
    input wire logic overvoltage_guard,
    input wire logic [7:0] backlight_level,
    input wire logic [7:0] flash_level,
    input wire logic converter_enable,
    input wire logic pump_charge,
    input wire logic pump_transfer
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    AST_PUMP_EXCL: assert property (!(pump_charge && pump_transfer))
        else $error("pump phases overlap");
    AST_PUMP_LEN: assert property ($rose(pump_charge) |=> ##[0:12] !pump_charge)
        else $error("charge phase too long");
    // three cycles allow for the level flop and the output flop
    AST_CONV_OFF: assert property ((backlight_level == 8'h00 && flash_level == 8'h00) [*3]
        |-> !converter_enable && !pump_charge && !pump_transfer)
        else $error("converter running with both levels zero");
    AST_CONV_ON: assert property ((backlight_level != 8'h00 || flash_level != 8'h00) [*3]
        |-> converter_enable)
        else $error("converter off with a level set");
    AST_OV_PAUSE: assert property (overvoltage_guard [*5] |-> !pump_charge && !pump_transfer)
        else $error("pump active during overvoltage");
    AST_ACK_EDGE: assert property ($changed(sda_dev_oe) |-> !scl)
        else $error("device moved sda while scl high");
    AST_ACK_HOLD: assert property ($rose(sda_dev_oe) |=> sda_dev_oe [*8])
        else $error("acknowledge released too early");
    AST_LEVEL_SCL: assert property (!$stable(backlight_level) || !$stable(flash_level) |-> scl)
        else $error("level changed outside a clock high");
    AST_ONE_BANK: assert property (!($changed(backlight_level) && $changed(flash_level)))
        else $error("both banks changed together");
    cover property ($rose(sda_dev_oe));
    cover property ($changed(flash_level));
    cover property (overvoltage_guard && converter_enable);
endmodule

// ---- led_driver_i2c_current_programming_tb.sv ----
`timescale 1ns/1ps
module led_driver_i2c_current_programming_tb import ldi_pkg::*;;
    typedef struct {logic [6:0] a; logic [7:0] s, v, bk, fl; int k;} ldi_row_t;
    logic clk, reset, ov, ws, rs, oe_q, fourth, conv, pc, pt;
    logic [1:0] addr;
    logic [7:0] wd, rdata, bk, fl, bk_ma, fl_ma, d;
    logic [10:0] mult;
    int bad_count, checks_done, cycles, acks, nc, nt;
    // backlight values keep bits 5,6 low
    // flash values keep bit 7 low
    ldi_row_t rows[8] = '{'{7'h39, 8'h01, 8'h9f, 8'h9f, 8'h00, 3},
        '{7'h39, 8'h02, 8'h7f, 8'h9f, 8'h7f, 3}, '{7'h39, 8'h01, 8'h1f, 8'h1f, 8'h7f, 3},
        '{7'h39, 8'h02, 8'h05, 8'h1f, 8'h05, 3}, '{7'h39, 8'h03, 8'haa, 8'h1f, 8'h05, 3},
        '{7'h3a, 8'h01, 8'h00, 8'h1f, 8'h05, 0}, '{7'h39, 8'h01, 8'h00, 8'h00, 8'h05, 3},
        '{7'h39, 8'h02, 8'h00, 8'h00, 8'h00, 3}};
    ldi_bus_if u_ldi_bus_if();
    ldi_host u_ldi_host(.clk(clk), .reset(reset), .bus(u_ldi_bus_if.host), .address(addr),
        .write_data(wd), .write_strobe(ws), .read_strobe(rs), .read_data(rdata));
    ldi_device u_ldi_device(.clk(clk), .reset(reset), .bus(u_ldi_bus_if.device),
        .overvoltage_guard(ov), .backlight_level(bk), .flash_level(fl),
        .fourth_backlight_enable(fourth), .backlight_multiplier(mult),
        .backlight_current_ma(bk_ma), .flash_current_ma(fl_ma), .converter_enable(conv),
        .pump_charge(pc), .pump_transfer(pt));
    ldi_asserts u_ldi_asserts(.clk(clk), .reset(reset), .scl(u_ldi_bus_if.scl),
        .sda_dev_oe(u_ldi_bus_if.sda_dev_oe), .overvoltage_guard(ov), .backlight_level(bk),
        .flash_level(fl), .converter_enable(conv), .pump_charge(pc), .pump_transfer(pt));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // ack edges counted on the wire; the run is cut short well past its length
    always @(posedge clk) begin
        oe_q <= u_ldi_bus_if.sda_dev_oe;
        if (u_ldi_bus_if.sda_dev_oe && !oe_q) acks++;
        if (u_ldi_bus_if.sda_dev_oe === 1'b1 && u_ldi_bus_if.sda !== 1'b0) check(1, 0);
        cycles++;
        if (cycles == 60000) begin
            bad_count++;
            give_verdict();
        end
    end
    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wd <= v;
        ws <= 1'b1;
        @(posedge clk);
        ws <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a);
        @(posedge clk);
        addr <= a;
        rs <= 1'b1;
        @(posedge clk);
        rs <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        d = 8'h01;
        while (d[0] !== 1'b0 && n < 4000) begin
            rd(LDI_REG_STATUS);
            n++;
        end
        check({10'h0, d[0]}, 11'h0);
    endtask
    task automatic frame(input logic [6:0] a, input logic [7:0] s, input logic [7:0] v);
        wr(LDI_REG_ADDRESS, {1'b0, a});
        wr(LDI_REG_TARGET, s);
        wr(LDI_REG_VALUE, v);
        wait_idle();
    endtask
    // current caps are applied to the outputs, never to the stored level
    task automatic levels(input logic [7:0] b, input logic [7:0] f);
        logic [7:0] bc, fc;
        logic [9:0] room;
        bc = ({3'h0, b[4:0]} > LDI_BK_CAP_MA) ? LDI_BK_CAP_MA : {3'h0, b[4:0]};
        room = (LDI_TOTAL_CAP_MA - (b[7] ? 10'h4 : 10'h3) * {2'h0, bc}) / 10'h4;
        fc = ({1'b0, f[6:0]} > LDI_FL_CAP_MA) ? LDI_FL_CAP_MA : {1'b0, f[6:0]};
        if ({2'h0, fc} > room) fc = room[7:0];
        check({3'h0, bk}, {3'h0, b});
        check({3'h0, fl}, {3'h0, f});
        check({10'h0, fourth}, {10'h0, b[7]});
        check(mult, {6'h0, b[4:0]} * LDI_MULT_STEP);
        check({3'h0, bk_ma}, {3'h0, bc});
        check({3'h0, fl_ma}, {3'h0, fc});
        check({10'h0, conv}, {10'h0, (b != 8'h00 || f != 8'h00)});
    endtask
    initial begin
        reset = 1'b1;
        ov = 1'b0;
        ws = 1'b0;
        rs = 1'b0;
        addr = 2'h0;
        wd = 8'h00;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            acks = 0;
            frame(rows[i].a, rows[i].s, rows[i].v);
            levels(rows[i].bk, rows[i].fl);
            check({10'h0, d[1]}, {10'h0, rows[i].a != LDI_DEV_ADDR});
            check(11'(acks), 11'(rows[i].k));
            check({9'h0, u_ldi_bus_if.scl, u_ldi_bus_if.sda}, 11'h3);
            $display("row %0d done", i);
        end
        frame(LDI_DEV_ADDR, LDI_SEL_FLASH, 8'h33);
        @(posedge clk);
        reset <= 1'b1;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1 levels(8'h00, 8'h00);
        rd(LDI_REG_TARGET);
        check({3'h0, d}, {3'h0, LDI_TARGET_RESET});
        rd(LDI_REG_ADDRESS);
        check({3'h0, d}, {4'h0, LDI_DEV_ADDR});
        rd(LDI_REG_VALUE);
        check({3'h0, d}, 11'h0);
        $display("reset test done");
        wr(LDI_REG_VALUE, 8'h9f);
        wr(LDI_REG_TARGET, LDI_SEL_FLASH);
        wait_idle();
        levels(8'h9f, 8'h00);
        $display("busy test done");
        @(posedge clk);
        ov <= 1'b1;
        repeat (8) @(posedge clk);
        repeat (20) begin
            @(posedge clk);
            #1 check({9'h0, pc, pt}, 11'h0);
        end
        ov <= 1'b0;
        nc = 0;
        nt = 0;
        repeat (60) begin
            @(posedge clk);
            #1 nc += pc;
            nt += pt;
        end
        check(11'(nc > 0 && nt > 0), 11'h1);
        $display("overvoltage test done");
        give_verdict();
    end
endmodule
